// ==== accr_pkg.sv ====
package accr_pkg;

  // register bank geometry
  localparam int unsigned ADDR_W = 6;
  localparam int unsigned DATA_W = 16;

  // word offsets
  localparam logic [5:0] OFS_CH3_GCAL_LO = 6'h1C;
  localparam logic [5:0] OFS_CHAN4_CONFIG     = 6'h1D;
  localparam logic [5:0] OFS_CH4_OCAL_HI = 6'h1E;
  localparam logic [5:0] OFS_CH4_OCAL_LO = 6'h1F;
  localparam logic [5:0] OFS_CH4_GCAL_HI = 6'h20;
  localparam logic [5:0] OFS_CH4_GCAL_LO = 6'h21;

  // reset values
  localparam logic [15:0] RST_CH3_GCAL_LO = 16'h0000;
  localparam logic [15:0] RST_CHAN4_CONFIG     = 16'h0000;
  localparam logic [15:0] RST_CH4_OCAL_HI = 16'h0000;
  localparam logic [15:0] RST_CH4_OCAL_LO = 16'h0000;
  localparam logic [15:0] RST_CH4_GCAL_HI = 16'h8000;
  localparam logic [15:0] RST_CH4_GCAL_LO = 16'h0000;

  // field positions
  localparam int unsigned PHASE_LSB = 6;
  localparam int unsigned PHASE_MSB = 15;
  localparam int unsigned DCBLK_BIT = 2;
  localparam int unsigned MUX_MSB   = 1;
  localparam int unsigned LOW_MSB   = 15;
  localparam int unsigned LOW_LSB   = 8;

  // write masks of writable bits, reserved bits read zero
  localparam logic [15:0] MASK_CFG  = 16'hFFC7;
  localparam logic [15:0] MASK_FULL = 16'hFFFF;
  localparam logic [15:0] MASK_LOW8 = 16'hFF00;

  // input source selection
  typedef enum logic [1:0] {
    ACCR_IN_EXT   = 2'b00,
    ACCR_IN_SHORT = 2'b01,
    ACCR_IN_TPOS  = 2'b10,
    ACCR_IN_TNEG  = 2'b11
  } accr_in_sel_t;

  // register bus request
  typedef struct packed {
    logic [5:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } accr_bus_req_t;

  // channel 4 decoded controls
  typedef struct packed {
    logic signed [9:0]  phase_delay;
    logic               dc_block_off;
    accr_in_sel_t       input_select;
    logic signed [23:0] offset_cal;
    logic [23:0]        gain_cal;
  } accr_ch4_ctl_t;

endpackage : accr_pkg

// ==== accr_reg_word.sv ====
`timescale 1ns/10ps
module accr_reg_word #(
  parameter logic [15:0] RESET_VAL = 16'h0000,
  parameter logic [15:0] WR_MASK   = 16'hFFFF
) (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  // write side
  input  wire logic        we,
  input  wire logic [15:0] wdata,
  // stored value
  output logic      [15:0] q
);

  typedef struct packed {
    logic [15:0] val;
  } accr_word_st_t;

  accr_word_st_t st_r;
  accr_word_st_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (we) begin
      st_nxt.val = wdata & WR_MASK;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      st_r <= '{val: RESET_VAL};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign q = st_r.val;

endmodule : accr_reg_word

// ==== accr_regs.sv ====
// The address-and-strobe port was decided locally.
`timescale 1ns/10ps
// Contract
// RULE1: channel 3 gain low eight bits live in bits 15:8 of its low word, read/write
// RULE2: gain value is unsigned fraction 0 to just under 2, scaled by 2^23
// RULE3: channel 4 phase delay in config bits 15:6, ten-bit two's complement
// RULE4: config bit 2 set bypasses DC block for channel 4, clear follows global
// RULE5: config bits 1:0 pick input: pins, shorted, positive or negative test
// RULE6: offset high word holds offset bits 23:8, read/write
// RULE7: offset low word bits 15:8 hold offset bits 7:0, read/write, reset zero
// RULE8: 24-bit offset value is signed two's complement
// RULE9: gain high word holds gain bits 23:8, resets to 8000h for unity
// RULE10: channel 4 config word resets to all zeros
// RULE11: both channel 4 offset words reset to zero
// RULE12: gain low word bits 15:8 hold gain bits 7:0, resets to zero
// RULE13: reserved bits read zero and ignore writes
// RULE14: each calibration value is current high word joined with low eight bits
module accr_regs (
  // clock and reset
  input  wire logic                   sys_clk,
  input  wire logic                   nrst,
  // register port
  input  wire logic [5:0]             reg_addr,
  input  wire logic [15:0]            reg_wdata,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  output logic      [15:0]            reg_rdata,
  // global dc block setting for channel 4
  input  wire logic                   global_dc_block_setting,
  // channel 3 gain low bits
  output logic      [7:0]             chan3_gain_cal_low_bits,
  // channel 4 controls
  output accr_pkg::accr_ch4_ctl_t     chan4_ctl,
  output logic                        chan4_dc_block_active,
  output logic                        chan4_use_pins,
  output logic                        chan4_inputs_shorted,
  output logic                        chan4_test_pos,
  output logic                        chan4_test_neg
);

  accr_pkg::accr_bus_req_t req;
  assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

  function automatic logic hit(input logic [5:0] a, input logic [5:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  function automatic logic [23:0] join_cal(input logic [15:0] hi, input logic [15:0] lo);
    join_cal = {hi, lo[accr_pkg::LOW_MSB:accr_pkg::LOW_LSB]};
  endfunction : join_cal

  logic [15:0] ch3_gcal_lo_q;
  logic [15:0] chan4_config_q;
  logic [15:0] ch4_ocal_hi_q;
  logic [15:0] ch4_ocal_lo_q;
  logic [15:0] ch4_gcal_hi_q;
  logic [15:0] ch4_gcal_lo_q;

  // storage words, writes masked so reserved bits stay zero
  accr_reg_word #(.RESET_VAL(accr_pkg::RST_CH3_GCAL_LO), .WR_MASK(accr_pkg::MASK_LOW8))
  u_ch3_gcal_lo ( // [RULE1] [RULE13]
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .we      (req.wr && hit(req.addr, accr_pkg::OFS_CH3_GCAL_LO)),
    .wdata   (req.wdata),
    .q       (ch3_gcal_lo_q)
  );

  accr_reg_word #(.RESET_VAL(accr_pkg::RST_CHAN4_CONFIG), .WR_MASK(accr_pkg::MASK_CFG))
  u_chan4_config ( // [RULE10] [RULE13]
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .we      (req.wr && hit(req.addr, accr_pkg::OFS_CHAN4_CONFIG)),
    .wdata   (req.wdata),
    .q       (chan4_config_q)
  );

  accr_reg_word #(.RESET_VAL(accr_pkg::RST_CH4_OCAL_HI), .WR_MASK(accr_pkg::MASK_FULL))
  u_ch4_ocal_hi ( // [RULE6] [RULE11]
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .we      (req.wr && hit(req.addr, accr_pkg::OFS_CH4_OCAL_HI)),
    .wdata   (req.wdata),
    .q       (ch4_ocal_hi_q)
  );

  accr_reg_word #(.RESET_VAL(accr_pkg::RST_CH4_OCAL_LO), .WR_MASK(accr_pkg::MASK_LOW8))
  u_ch4_ocal_lo ( // [RULE7] [RULE11] [RULE13]
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .we      (req.wr && hit(req.addr, accr_pkg::OFS_CH4_OCAL_LO)),
    .wdata   (req.wdata),
    .q       (ch4_ocal_lo_q)
  );

  accr_reg_word #(.RESET_VAL(accr_pkg::RST_CH4_GCAL_HI), .WR_MASK(accr_pkg::MASK_FULL))
  u_ch4_gcal_hi ( // [RULE9]
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .we      (req.wr && hit(req.addr, accr_pkg::OFS_CH4_GCAL_HI)),
    .wdata   (req.wdata),
    .q       (ch4_gcal_hi_q)
  );

  accr_reg_word #(.RESET_VAL(accr_pkg::RST_CH4_GCAL_LO), .WR_MASK(accr_pkg::MASK_LOW8))
  u_ch4_gcal_lo ( // [RULE12] [RULE13]
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .we      (req.wr && hit(req.addr, accr_pkg::OFS_CH4_GCAL_LO)),
    .wdata   (req.wdata),
    .q       (ch4_gcal_lo_q)
  );

  // read path state
  typedef struct packed {
    logic [15:0] rdata;
  } accr_rd_st_t;

  accr_rd_st_t st_r;
  accr_rd_st_t st_nxt;

  always_comb begin
    st_nxt = '{rdata: 16'h0000};
    if (req.rd) begin
      unique case (req.addr)
        accr_pkg::OFS_CH3_GCAL_LO: st_nxt.rdata = ch3_gcal_lo_q; // [RULE1]
        accr_pkg::OFS_CHAN4_CONFIG:     st_nxt.rdata = chan4_config_q;     // [RULE13]
        accr_pkg::OFS_CH4_OCAL_HI: st_nxt.rdata = ch4_ocal_hi_q;
        accr_pkg::OFS_CH4_OCAL_LO: st_nxt.rdata = ch4_ocal_lo_q;
        accr_pkg::OFS_CH4_GCAL_HI: st_nxt.rdata = ch4_gcal_hi_q;
        accr_pkg::OFS_CH4_GCAL_LO: st_nxt.rdata = ch4_gcal_lo_q;
        default:                   st_nxt.rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      st_r <= '{rdata: 16'h0000};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign reg_rdata = st_r.rdata;

  // decoded controls for the datapath
  assign chan3_gain_cal_low_bits = ch3_gcal_lo_q[accr_pkg::LOW_MSB:accr_pkg::LOW_LSB]; // [RULE1]

  always_comb begin
    chan4_ctl.phase_delay  = chan4_config_q[accr_pkg::PHASE_MSB:accr_pkg::PHASE_LSB]; // [RULE3]
    chan4_ctl.dc_block_off = chan4_config_q[accr_pkg::DCBLK_BIT];                     // [RULE4]
    chan4_ctl.input_select = accr_pkg::accr_in_sel_t'(chan4_config_q[accr_pkg::MUX_MSB:0]); // [RULE5]
    chan4_ctl.offset_cal   = join_cal(ch4_ocal_hi_q, ch4_ocal_lo_q); // [RULE8] [RULE14]
    chan4_ctl.gain_cal     = join_cal(ch4_gcal_hi_q, ch4_gcal_lo_q); // [RULE2] [RULE14]
  end

  // dc block bypass overrides the global setting
  assign chan4_dc_block_active = !chan4_ctl.dc_block_off && global_dc_block_setting; // [RULE4]

  // one-hot input source decode
  assign chan4_use_pins       = (chan4_ctl.input_select == accr_pkg::ACCR_IN_EXT);   // [RULE5]
  assign chan4_inputs_shorted = (chan4_ctl.input_select == accr_pkg::ACCR_IN_SHORT); // [RULE5]
  assign chan4_test_pos       = (chan4_ctl.input_select == accr_pkg::ACCR_IN_TPOS);  // [RULE5]
  assign chan4_test_neg       = (chan4_ctl.input_select == accr_pkg::ACCR_IN_TNEG);  // [RULE5]

endmodule : accr_regs

// ==== accr_regs_props.sv ====
`timescale 1ns/10ps
module accr_regs_props (
  // clock and reset
  input wire logic                    sys_clk,
  input wire logic                    nrst,
  // register port
  input wire logic [5:0]              reg_addr,
  input wire logic [15:0]             reg_wdata,
  input wire logic                    reg_wr,
  input wire logic                    reg_rd,
  input wire logic [15:0]             reg_rdata,
  // controls
  input wire logic                    global_dc_block_setting,
  input wire logic [7:0]              chan3_gain_cal_low_bits,
  input wire accr_pkg::accr_ch4_ctl_t chan4_ctl,
  input wire logic                    chan4_dc_block_active,
  input wire logic                    chan4_use_pins,
  input wire logic                    chan4_inputs_shorted,
  input wire logic                    chan4_test_pos,
  input wire logic                    chan4_test_neg
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  chk_rsv_read: assert property (reg_rd && reg_addr == 6'h1D |=> reg_rdata[5:3] == 3'h0)
    else $error("reserved bits read nonzero");
  chk_dc_follow: assert property (chan4_dc_block_active ==
    (!chan4_ctl.dc_block_off && global_dc_block_setting)) else $error("dc block wrong");
  chk_src_decode: assert property ({chan4_test_neg, chan4_test_pos, chan4_inputs_shorted,
    chan4_use_pins} == 4'h1 << chan4_ctl.input_select) else $error("source decode wrong");
  chk_cfg_write: assert property (reg_wr && reg_addr == 6'h1D |=>
    chan4_ctl.phase_delay == $past(reg_wdata[15:6])) else $error("phase not stored");
  chk_ocal_high: assert property (reg_wr && reg_addr == 6'h1E |=>
    chan4_ctl.offset_cal[23:8] == $past(reg_wdata)) else $error("offset high not stored");
  chk_ocal_low: assert property (reg_wr && reg_addr == 6'h1F |=>
    chan4_ctl.offset_cal[7:0] == $past(reg_wdata[15:8])) else $error("offset low not stored");
  chk_gain_high: assert property (reg_wr && reg_addr == 6'h20 |=>
    chan4_ctl.gain_cal[23:8] == $past(reg_wdata)) else $error("gain high not stored");
  chk_ch3_gain: assert property (reg_wr && reg_addr == 6'h1C |=>
    chan3_gain_cal_low_bits == $past(reg_wdata[15:8])) else $error("ch3 gain not stored");
  chk_ctl_hold: assert property (!reg_wr |=> $stable(chan4_ctl))
    else $error("controls changed without write");
  chk_gain_low: assert property (reg_wr && reg_addr == 6'h21 |=>
    chan4_ctl.gain_cal[7:0] == $past(reg_wdata[15:8])) else $error("gain low not stored");
  chk_low_rsv: assert property (reg_rd && (reg_addr == 6'h1C || reg_addr == 6'h1F ||
    reg_addr == 6'h21) |=> reg_rdata[7:0] == 8'h00) else $error("low word reserved nonzero");
  cover property (reg_wr && reg_addr == 6'h1D);
  cover property (reg_rd && reg_addr == 6'h21);
  cover property (chan4_test_neg && chan4_ctl.dc_block_off);
endmodule : accr_regs_props

// ==== tb_accr_regs.sv ====
`timescale 1ns/10ps
module tb_accr_regs;
  logic                    sys_clk, nrst, reg_wr, reg_rd, global_dc_block_setting, rd_d;
  logic [5:0]              reg_addr;
  logic [15:0]             reg_wdata, reg_rdata, rv, wd;
  logic [7:0]              chan3_gain_cal_low_bits;
  accr_pkg::accr_ch4_ctl_t chan4_ctl;
  logic                    chan4_dc_block_active, chan4_use_pins, chan4_inputs_shorted;
  logic                    chan4_test_pos, chan4_test_neg;
  logic [15:0]             m [64];
  logic [15:0]             q [$];
  int                      failures, checks, seed, i;

  accr_regs i_accr_regs (.*);

  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  function automatic logic [15:0] msk(logic [5:0] a);
    case (a)
      6'h1C, 6'h1F, 6'h21: msk = 16'hFF00;
      6'h1D: msk = 16'hFFC7;
      6'h1E, 6'h20: msk = 16'hFFFF;
      default: msk = 16'h0000;
    endcase
  endfunction : msk

  task automatic cmp(string n, logic [63:0] e, logic [63:0] s);
    checks++;
    if (e !== s) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask : cmp

  // one bus cycle; expected read data noted in the queue
  task automatic bus(logic w, logic r, logic [5:0] a, logic [15:0] d);
    reg_wr    <= w;
    reg_rd    <= r;
    reg_addr  <= a;
    reg_wdata <= d;
    if (w) m[a] = d & msk(a);
    if (r) q.push_back(m[a]);
    @(posedge sys_clk);
  endtask : bus

  task automatic finish_test;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : finish_test

  // monitor: read data one cycle after the strobe, controls once writes have landed
  always @(posedge sys_clk) rd_d <= reg_rd;
  always @(negedge sys_clk) begin
    if (rd_d) cmp("rdata", q.pop_front(), reg_rdata);
    if (nrst && !reg_wr) begin
      cmp("ctl", {m[6'h1D][15:6], m[6'h1D][2:0], m[6'h1E], m[6'h1F][15:8], m[6'h20],
        m[6'h21][15:8]}, chan4_ctl);
      cmp("ch3", m[6'h1C][15:8], chan3_gain_cal_low_bits);
      cmp("dc", !m[6'h1D][2] && global_dc_block_setting, chan4_dc_block_active);
      cmp("src", 4'h1 << m[6'h1D][1:0], {chan4_test_neg, chan4_test_pos,
        chan4_inputs_shorted, chan4_use_pins});
    end
  end

  initial begin
    seed = 32'hA0F22858;
    nrst = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 6'h00;
    reg_wdata = 16'h0000;
    global_dc_block_setting = 1'b0;
    foreach (m[k]) m[k] = 16'h0000;
    m[6'h20] = 16'h8000;
    repeat (5) @(posedge sys_clk);
    nrst <= 1'b1;
    @(posedge sys_clk);
    // reset values, unmapped neighbours read zero
    for (i = 'h1B; i <= 'h22; i++) bus(1'b0, 1'b1, i[5:0], 16'h0000);
    // every source and dc block combination, reserved bits written random
    for (i = 0; i < 16; i++) begin
      rv = 16'($random(seed));
      global_dc_block_setting <= i[3];
      bus(1'b1, 1'b0, 6'h1D, {rv[15:3], i[2:0]});
      bus(1'b0, 1'b1, 6'h1D, 16'h0000);
    end
    // random back-to-back traffic over the bank and its edges
    for (i = 0; i < 300; i++) begin
      rv = 16'($random(seed));
      wd = 16'($random(seed));
      global_dc_block_setting <= rv[4];
      bus(rv[0], !rv[0], 6'h1B + 6'(rv[3:1]), wd);
    end
    bus(1'b0, 1'b0, 6'h00, 16'h0000);
    repeat (2) @(posedge sys_clk);
    // reset in mid-run puts every word back to its reset value
    nrst <= 1'b0;
    foreach (m[k]) m[k] = 16'h0000;
    m[6'h20] = 16'h8000;
    repeat (2) @(posedge sys_clk);
    nrst <= 1'b1;
    @(posedge sys_clk);
    for (i = 'h1C; i <= 'h21; i++) bus(1'b0, 1'b1, i[5:0], 16'h0000);
    bus(1'b0, 1'b0, 6'h00, 16'h0000);
    repeat (2) @(posedge sys_clk);
    finish_test();
  end
endmodule : tb_accr_regs

bind accr_regs accr_regs_props i_accr_regs_props (.*);
